// ===== dci_cpu_intc.sv
/*
 * Behavioural model of the CPU interrupt controller that receives the channel's requests.
 * It assumes one request pulse per interrupt, sampled on the bench clock.
 */
`timescale 1ns/1ps

module dci_cpu_intc (
	// Clock and reset.
	input  wire logic  clk,
	input  wire logic  rst_n,
	// Request and masks.
	input  wire logic  irq_req,
	input  wire logic  irq_mask_en,
	input  wire logic  global_irq_mask_bit,
	// Requests actually serviced.
	output logic [15:0] serviced_count
);
	// The channel only asks for service; the two masks decide whether it happens.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			serviced_count <= 16'h0000;
		else if (irq_req && irq_mask_en && !global_irq_mask_bit)
			serviced_count <= serviced_count + 16'h0001;
	end
endmodule // dci_cpu_intc

// ===== dci_irq_gen.sv
/*
 * Interrupt request generation for one DMA channel: multiframe end-of-frame
 * and end-of-block points, circular-buffer half and full points.
 * Assumes the transfer engine reports each completed element with a one-cycle
 * step strobe on the same clock, together with counts after the decrement.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - With the interrupt enable clear, no request is ever raised.
// - With the enable set, requests follow timing select and transfer mode.
// - Transfer mode 1 selects circular-buffer, 0 selects multiframe operation.
// - Multiframe, timing select 0: one request when the whole block completes.
// - Multiframe, timing select 1: request at each frame end and block end.
// - A frame ends when the frame counter reaches zero.
// - A block ends only when element and frame counters are both zero.
// - Circular, select 0: full only; select 1: half and full points.
// - Half-point decisions compare both the current and the calculated next address.
// - Full fires when next address wraps to base, or to maximum if negative.
// - First variant, positive step: half fires when next reaches the halfway point.
// - Both variants, negative step: half fires when next drops below halfway.
// - Second variant, positive step: half fires when next passes halfway.
// - Eight words by +1: first variant fires into offset four, second five.
// - Next address wraps around the buffer ends by the excess offset.
module dci_irq_gen import dci_pkg::*; #(
	parameter int VARIANT = VARIANT_GE
) (
	// Clock and reset.
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      ce,
	// Channel mode control.
	input  wire dci_mode_t                 channel_mode_control,
	input  wire dci_buf_t                  buf_cfg,
	// Transfer progress from the channel engine.
	input  wire logic                      step_valid,
	input  wire logic [ADDR_W-1:0]         cur_addr,
	input  wire logic signed [ADDR_W-1:0]  addr_step,
	input  wire logic [ELEM_W-1:0]         elem_count,
	input  wire logic [FRAME_W-1:0]        frame_count,
	// Results.
	output logic [ADDR_W-1:0]              next_addr,
	output logic                           dma_irq
);

	logic                rst_s1_reg;
	logic                rst_s2_reg;
	logic                rst_l;
	logic [ADDR_W-1:0]   calc_next;
	logic                calc_wrap;
	logic [ADDR_W-1:0]   halfway;
	logic                half_hit;
	logic                full_hit;
	logic                frame_end;
	logic                block_end;
	logic                irq_next;
	logic                irq_reg;
	logic [ADDR_W-1:0]   next_addr_reg;
	logic [FRAME_W-1:0]  frame_prev_reg;

	// Reset is released through two flops so the release is glitch-free.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign rst_l = rst_s2_reg;

	dci_next_addr u_next (
		.cur_addr  (cur_addr),
		.step      (addr_step),
		.buf_cfg   (buf_cfg),
		.next_addr (calc_next),
		.wrapped   (calc_wrap)
	);

	function automatic logic [ADDR_W-1:0] half_point(input dci_buf_t b);
		half_point = b.base + (b.size >> 1);
	endfunction

	assign halfway = half_point(buf_cfg);

	// Crossing tests use both ends of the step so a point fires once per pass.
	always_comb begin
		half_hit = 1'b0;
		if (addr_step[ADDR_W-1]) begin
			half_hit = !calc_wrap && cur_addr >= halfway && calc_next < halfway;
		end else if (VARIANT == VARIANT_GE) begin
			half_hit = !calc_wrap && cur_addr < halfway && calc_next >= halfway;
		end else begin
			half_hit = !calc_wrap && cur_addr <= halfway && calc_next > halfway;
		end
	end

	assign full_hit  = calc_wrap;
	assign block_end = elem_count == '0 && frame_count == '0;
	// The frame counter only moves at frame boundaries, so a change to zero
	// is the end of a frame; the final block end is caught separately.
	assign frame_end = frame_count == '0 && frame_prev_reg != '0;

	always_comb begin
		irq_next = 1'b0;
		if (step_valid && channel_mode_control.channel_irq_enable) begin
			case (channel_mode_control.transfer_mode_select)
				MODE_CIRCULAR: begin
					if (channel_mode_control.irq_timing_select == TSEL_FINE) begin
						irq_next = full_hit || half_hit;
					end else begin
						irq_next = full_hit;
					end
				end
				default: begin
					if (channel_mode_control.irq_timing_select == TSEL_FINE) begin
						irq_next = frame_end || block_end;
					end else begin
						irq_next = block_end;
					end
				end
			endcase
		end
	end

	// One pulse per qualifying step; masking by the CPU happens downstream.
	always_ff @(posedge clk or negedge rst_l) begin
		if (!rst_l) begin
			irq_reg <= 1'b0;
		end else if (ce) begin
			irq_reg <= irq_next;
		end
	end

	always_ff @(posedge clk or negedge rst_l) begin
		if (!rst_l) begin
			next_addr_reg <= RST_ADDR;
		end else if (ce && step_valid) begin
			next_addr_reg <= calc_next;
		end
	end

	always_ff @(posedge clk or negedge rst_l) begin
		if (!rst_l) begin
			frame_prev_reg <= RST_FRAME;
		end else if (ce && step_valid) begin
			frame_prev_reg <= frame_count;
		end
	end

	assign dma_irq   = irq_reg;
	assign next_addr = next_addr_reg;

	a_disabled_quiet: assert property (@(posedge clk) disable iff (!rst_l)
		ce && !channel_mode_control.channel_irq_enable |=> !dma_irq)
		else $error("request raised while interrupts disabled");

	a_irq_has_step: assert property (@(posedge clk) disable iff (!rst_l)
		$rose(dma_irq) |-> $past(step_valid) && $past(ce))
		else $error("request without a transfer step");

	a_block_end_irq: assert property (@(posedge clk) disable iff (!rst_l)
		ce && step_valid && channel_mode_control.channel_irq_enable
		&& channel_mode_control.transfer_mode_select == MODE_MULTIFRAME
		&& elem_count == '0 && frame_count == '0 |=> dma_irq)
		else $error("block end did not raise a request");

	a_coarse_only_block: assert property (@(posedge clk) disable iff (!rst_l)
		ce && channel_mode_control.transfer_mode_select == MODE_MULTIFRAME
		&& channel_mode_control.irq_timing_select == TSEL_COARSE
		&& elem_count != '0 |=> !dma_irq)
		else $error("multiframe coarse request before block end");

	a_frame_end_irq: assert property (@(posedge clk) disable iff (!rst_l)
		ce && step_valid && channel_mode_control.channel_irq_enable
		&& channel_mode_control.transfer_mode_select == MODE_MULTIFRAME
		&& channel_mode_control.irq_timing_select == TSEL_FINE
		&& frame_count == '0 && frame_prev_reg != '0 |=> dma_irq)
		else $error("frame end did not raise a request");

	a_wrap_full_irq: assert property (@(posedge clk) disable iff (!rst_l)
		ce && step_valid && channel_mode_control.channel_irq_enable
		&& channel_mode_control.transfer_mode_select == MODE_CIRCULAR
		&& calc_wrap |=> dma_irq ##1 (!$past(ce) || $past(irq_next) || !dma_irq))
		else $error("buffer wrap did not raise a request");

	a_half_suppressed: assert property (@(posedge clk) disable iff (!rst_l)
		ce && step_valid && channel_mode_control.transfer_mode_select == MODE_CIRCULAR
		&& channel_mode_control.irq_timing_select == TSEL_COARSE
		&& !calc_wrap |=> !dma_irq)
		else $error("half point fired with coarse timing");

	a_half_point_irq: assert property (@(posedge clk) disable iff (!rst_l)
		ce && step_valid && channel_mode_control.channel_irq_enable
		&& channel_mode_control.transfer_mode_select == MODE_CIRCULAR
		&& channel_mode_control.irq_timing_select == TSEL_FINE
		&& !addr_step[ADDR_W-1] && VARIANT == VARIANT_GE
		&& cur_addr < halfway && calc_next >= halfway && !calc_wrap |=> dma_irq)
		else $error("half point missed on positive step");

	a_half_gt_irq: assert property (@(posedge clk) disable iff (!rst_l)
		ce && step_valid && channel_mode_control.channel_irq_enable
		&& channel_mode_control.transfer_mode_select == MODE_CIRCULAR
		&& channel_mode_control.irq_timing_select == TSEL_FINE
		&& !addr_step[ADDR_W-1] && VARIANT == VARIANT_GT
		&& cur_addr <= halfway && calc_next > halfway && !calc_wrap |=> dma_irq)
		else $error("half point missed past halfway");

	a_ce_hold_irq: assert property (@(posedge clk) disable iff (!rst_l)
		!ce |=> $stable(dma_irq) && $stable(next_addr))
		else $error("state moved while clock enable low");

	a_half_neg_irq: assert property (@(posedge clk) disable iff (!rst_l)
		ce && step_valid && channel_mode_control.channel_irq_enable
		&& channel_mode_control.transfer_mode_select == MODE_CIRCULAR
		&& channel_mode_control.irq_timing_select == TSEL_FINE
		&& addr_step[ADDR_W-1] && cur_addr >= halfway && calc_next < halfway
		&& !calc_wrap |=> dma_irq)
		else $error("half point missed on negative step");

	a_next_addr_held: assert property (@(posedge clk) disable iff (!rst_l)
		ce && step_valid |=> next_addr == $past(calc_next))
		else $error("next address not captured");

endmodule // dci_irq_gen

// ===== dci_irq_gen_bench.sv
/*
 * Self-checking bench for the channel interrupt generator, both half-buffer variants.
 * It assumes the design answers one cycle after each step that is taken.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %s expected %h seen %h", n, e, g); end end

module dci_irq_gen_bench import dci_pkg::*; ;
	logic               clk = 0;
	logic               rst_n = 0;
	logic               ce = 0;
	logic               step_valid = 0;
	logic               imask = 1;
	logic               gmask = 0;
	dci_mode_t          mode = '0;
	dci_buf_t           bcfg = '0;
	logic [ADDR_W-1:0]  cur = '0;
	logic [ADDR_W-1:0]  st = '0;
	logic [ELEM_W-1:0]  ec = '0;
	logic [FRAME_W-1:0] fc = '0;
	logic [FRAME_W-1:0] prev_fc = '0;
	logic [ADDR_W-1:0]  nx0, nx1;
	logic               irq0, irq1, pend = 0, ce_d = 0, live = 0;
	logic [1:0]         lvl = '0;
	logic [17:0]        e, x, expq[$];
	logic [15:0]        svc;
	int                 bad_count = 0, cmp_count = 0, nsvc = 0, c, s, sz;

	always #5 clk = ~clk;

	dci_irq_gen #(.VARIANT(VARIANT_GE)) uut (.clk(clk), .rst_n(rst_n), .ce(ce),
		.channel_mode_control(mode), .buf_cfg(bcfg), .step_valid(step_valid), .cur_addr(cur),
		.addr_step(st), .elem_count(ec), .frame_count(fc), .next_addr(nx0), .dma_irq(irq0));
	dci_irq_gen #(.VARIANT(VARIANT_GT)) uut_gt (.clk(clk), .rst_n(rst_n), .ce(ce),
		.channel_mode_control(mode), .buf_cfg(bcfg), .step_valid(step_valid), .cur_addr(cur),
		.addr_step(st), .elem_count(ec), .frame_count(fc), .next_addr(nx1), .dma_irq(irq1));
	dci_cpu_intc far (.clk(clk), .rst_n(rst_n), .irq_req(irq0), .irq_mask_en(imask),
		.global_irq_mask_bit(gmask), .serviced_count(svc));

	function automatic logic [17:0] ref_circ(int c, int s);
		int  b, mx, h, n;
		logic w, hg, ht;
		b = bcfg.base;
		mx = b + bcfg.size - 1;
		h = b + bcfg.size / 2;
		n = c + s;
		w = 1;
		if (n > mx) n = b + n - mx - 1;
		else if (n < b) n = mx - (b - n - 1);
		else w = 0;
		hg = s > 0 ? c < h && n >= h : c >= h && n < h;
		ht = s > 0 ? c <= h && n > h : c >= h && n < h;
		return {mode.channel_irq_enable & (w | mode.irq_timing_select & ht),
			mode.channel_irq_enable & (w | mode.irq_timing_select & hg), n[15:0]};
	endfunction

	function automatic logic [17:0] ref_mf(logic [15:0] ecnt, logic [7:0] f);
		logic fe, be;
		fe = f == 0 && prev_fc != 0;
		be = ecnt == 0 && f == 0;
		be = mode.channel_irq_enable & (be | mode.irq_timing_select & fe);
		return {be, be, 16'h0000};
	endfunction

	// Steps stay back to back; only idle lowers the strobe, so no signal is set twice at once.
	task automatic step(int c, int s, logic [15:0] ecnt, logic [7:0] f, logic [17:0] ex);
		ce = $urandom % 4 != 0;
		step_valid = 1;
		cur = c[15:0];
		st = s[15:0];
		ec = ecnt;
		fc = f;
		if (ce) begin
			expq.push_back(ex);
			prev_fc = f;
		end
		@(posedge clk);
		#1;
	endtask

	task automatic idle(int n);
		step_valid = 0;
		ce = 1;
		repeat (n) @(posedge clk);
		#1;
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// The output is only re-evaluated on enabled edges, so the expected level holds otherwise.
	always @(posedge clk) begin
		if (ce_d) begin
			e = pend ? expq.pop_front() : 18'h00000;
			lvl = e[17:16];
			if (pend && mode.transfer_mode_select) `CHK("next_addr", {2{e[15:0]}}, {nx1, nx0})
		end
		// The very first edge is the one that first resets the design, so its outputs
		// are still unknown there.
		if (live) `CHK("dma_irq", lvl, {irq1, irq0})
		if (lvl[0] && imask && !gmask) nsvc++;
		pend <= step_valid && ce;
		ce_d <= ce;
		live <= 1'b1;
	end

	initial begin
		#300_000;
		bad_count++;
		report_and_stop();
	end

	initial begin
		void'($urandom(32'h0e5a_7b79));
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1;
		repeat (4) @(posedge clk);
		#1;
		idle(2);
		for (int k = 0; k < 48; k++) begin
			mode = {k[1:0] != 0, k[2], MODE_CIRCULAR};
			sz = k[3] ? 7 : 8;
			s = k[4] ? -1 : 1;
			c = s > 0 ? 16'h0040 : 16'h0040 + sz - 1;
			if (k >= 32) begin
				sz = 4 + $urandom % 17;
				s = 1 + $urandom % 3;
				if ($urandom % 2) s = -s;
				c = 16'h0040 + $urandom % sz;
			end
			bcfg = {16'h0040, sz[15:0]};
			imask = $urandom % 2;
			gmask = $urandom % 2;
			repeat (2 * sz) begin
				x = ref_circ(c, s);
				step(c, s, 16'h0005, 8'h01, x);
				c = x[15:0];
			end
			idle(3);
			$display("circular test %0d done", k);
		end
		for (int k = 0; k < 8; k++) begin
			mode = {k[0], k[1], MODE_MULTIFRAME};
			gmask = k[2];
			for (int f = 2; f >= 0; f--)
				for (int n = 2; n >= 0; n--)
					step($urandom, $urandom, n[15:0], f[7:0], ref_mf(n[15:0], f[7:0]));
			idle(3);
			$display("multiframe test %0d done", k);
		end
		`CHK("serviced", nsvc[15:0], svc)
		report_and_stop();
	end
endmodule // dci_irq_gen_bench

// ===== dci_next_addr.sv
/*
 * Circular-buffer next-address calculator with wrap detection.
 * Assumes base and size describe a buffer that lies inside the address space.
 */
`timescale 1ns/1ps

module dci_next_addr import dci_pkg::*; (
	// Current position and step.
	input  wire logic [ADDR_W-1:0]        cur_addr,
	input  wire logic signed [ADDR_W-1:0] step,
	// Buffer placement.
	input  wire dci_buf_t                 buf_cfg,
	// Result.
	output logic [ADDR_W-1:0]             next_addr,
	output logic                          wrapped
);

	logic signed [ADDR_W+1:0] sum;
	logic signed [ADDR_W+1:0] base_s;
	logic signed [ADDR_W+1:0] max_s;
	logic signed [ADDR_W+1:0] res;

	// Stepping past the top re-enters at the base plus the excess; below the
	// base it re-enters at the top less the excess.
	always_comb begin
		base_s    = $signed({2'b00, buf_cfg.base});
		max_s     = base_s + $signed({2'b00, buf_cfg.size}) - 18'sd1;
		sum       = $signed({2'b00, cur_addr}) + 18'(step);
		res       = sum;
		wrapped   = 1'b0;
		if (!step[ADDR_W-1] && sum > max_s) begin
			res     = base_s + (sum - max_s - 18'sd1);
			wrapped = 1'b1;
		end else if (step[ADDR_W-1] && sum < base_s) begin
			res     = max_s - (base_s - sum - 18'sd1);
			wrapped = 1'b1;
		end
		next_addr = res[ADDR_W-1:0];
	end

endmodule // dci_next_addr

// ===== dci_pkg.sv
/*
 * Shared types and constants for the DMA channel interrupt generator.
 * Assumes a 16-bit word address space and 8-bit frame counts.
 */
package dci_pkg;

	localparam int ADDR_W  = 16;
	localparam int ELEM_W  = 16;
	localparam int FRAME_W = 8;

	// Mode field encodings.
	localparam logic MODE_CIRCULAR   = 1'b1;
	localparam logic MODE_MULTIFRAME = 1'b0;
	localparam logic TSEL_COARSE     = 1'b0;
	localparam logic TSEL_FINE       = 1'b1;

	// Values after reset.
	localparam logic [ADDR_W-1:0]  RST_ADDR  = 16'h0000;
	localparam logic [FRAME_W-1:0] RST_FRAME = 8'h00;

	// Variant selection for the half-buffer comparison.
	localparam int VARIANT_GE = 0;
	localparam int VARIANT_GT = 1;

	typedef struct packed {
		logic channel_irq_enable;
		logic irq_timing_select;
		logic transfer_mode_select;
	} dci_mode_t;

	typedef struct packed {
		logic [ADDR_W-1:0] base;
		logic [ADDR_W-1:0] size;
	} dci_buf_t;

endpackage
